// ===== pmc_pkg.sv
// Constants, register map and types of the global power mode controller
// Functional notes
// [R1] Exactly four global modes: active, alternate active, sleep, hibernate, by falling consumption.
// [R2] In active mode each subsystem has its own enable bit in the active template.
// [R3] A disabled resource has its digital clocks gated and its analog bias switched off.
// [R4] Template writes act at once, with no mode transition needed.
// [R5] The processor may clear its own template bit; the next wakeup sets it again.
// [R6] Any wakeup forces the global mode to active and enables the processor.
// [R7] After reset the global mode is active.
// [R8] Sleep disables most resources whatever the templates hold.
// [R9] Hibernate keeps state, stops all clocks, wakes only on pin interrupts.
// [R10] Alternate active uses its own, usually smaller, template of enabled subsystems.
// [R11] Core regulators are enabled after reset; firmware may switch them off.
// [R12] In sleep the digital and analog core regulators run buzzed.
// [R13] In hibernate only the hibernate regulator stays on.
// [R14] Leaving sleep takes at most fifteen microseconds of resume time.
// [R15] Leaving hibernate completes in under one hundred microseconds after the pin interrupt.
// [R16] Wakeup sources are configurable, from enabled interrupts or reset; wakeup restores active.
// [R17] Sleep wake sources: comparator, pin unit, two-wire match, clock, timewheel, voltage detect.
// [R18] Firmware leaves active only through the mode request register.
package pmc_pkg;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_ALT,
    ST_SLEEP,
    ST_HIB,
    ST_RESUME
  } state_t;

  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_ALT    = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h2;
  localparam logic [1:0] MODE_HIB    = 2'h3;

  localparam int unsigned SUBSYS_W = 8;
  localparam int unsigned CPU_BIT  = 0;

  localparam int unsigned WAKE_W          = 6;
  localparam int unsigned WAKE_COMPARATOR = 0;
  localparam int unsigned WAKE_PIN_UNIT   = 1;
  localparam int unsigned WAKE_TWO_WIRE   = 2;
  localparam int unsigned WAKE_RTC        = 3;
  localparam int unsigned WAKE_TIMEWHEEL  = 4;
  localparam int unsigned WAKE_LOW_VOLT   = 5;

  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_WAKE      = 0;
  localparam int unsigned IRQ_RESUMED   = 1;
  localparam int unsigned IRQ_LOW_POWER = 2;

  localparam logic [7:0] ADDR_ACT_TMPL   = 8'h00;
  localparam logic [7:0] ADDR_ALT_TMPL   = 8'h04;
  localparam logic [7:0] ADDR_MODE_REQ   = 8'h08;
  localparam logic [7:0] ADDR_MODE_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_EN    = 8'h10;
  localparam logic [7:0] ADDR_REG_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;

  localparam int unsigned MODE_LSB     = 0;
  localparam int unsigned RESUMING_BIT = 2;
  localparam int unsigned REG_DIG_BIT  = 0;
  localparam int unsigned REG_ANA_BIT  = 1;

  localparam logic [31:0] RST_TMPL     = 32'hFFFF_FFFF;
  localparam logic [5:0]  RST_WAKE_EN  = 6'h3F;
  localparam logic [1:0]  RST_REG_CTRL = 2'h3;
  localparam logic [2:0]  RST_IRQ_EN   = 3'h0;

  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned SLEEP_RESUME_NS = 15000;
  localparam int unsigned HIB_RESUME_NS   = 100000;
  localparam logic [15:0] SLEEP_RESUME_CYC = 16'(SLEEP_RESUME_NS * CLK_MHZ / 1000);
  localparam logic [15:0] HIB_RESUME_CYC   = 16'(HIB_RESUME_NS * CLK_MHZ / 1000 - 1);

endpackage : pmc_pkg

// ===== input_sync.sv
// Three-stage synchroniser with agreement filter for pin-side inputs
`timescale 1ns/10ps
module input_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] next_level;

  // A bit follows only when the second and third stages agree
  assign next_level = (stage2 & stage3) | (level_out & (stage2 | stage3));

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      level_out <= '0;
    end else if (ce_in) begin
      stage1    <= async_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= next_level;
    end
  end

endmodule : input_sync

// ===== power_mode_controller.sv
// Global power mode controller with Wishbone register slave
`timescale 1ns/10ps
module power_mode_controller #(
  parameter int unsigned          SUBSYS_W         = pmc_pkg::SUBSYS_W,
  parameter logic [15:0]          SLEEP_RESUME_CYC = pmc_pkg::SLEEP_RESUME_CYC,
  parameter logic [15:0]          HIB_RESUME_CYC   = pmc_pkg::HIB_RESUME_CYC,
  parameter logic [SUBSYS_W-1:0]  SLEEP_KEEP       = '0
) (
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                ce_in,
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [7:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic      [31:0]         wb_dat_out,
  output logic                     wb_ack_out,
  input  wire logic [5:0]          wake_src_in,
  input  wire logic                irq_pending_in,
  output logic      [SUBSYS_W-1:0] subsys_clk_en_out,
  output logic      [SUBSYS_W-1:0] subsys_bias_en_out,
  output logic                     dig_reg_en_out,
  output logic                     ana_reg_en_out,
  output logic                     reg_buzz_out,
  output logic                     hib_reg_en_out,
  output logic                     clk_stop_out,
  output logic                     low_speed_clk_out,
  output logic      [1:0]          mode_out,
  output logic                     resuming_out,
  output logic                     irq_out
);

  // Byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge_sel = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_sel

  // Zero extension of a template to a bus word
  function automatic logic [31:0] pad_word(input logic [SUBSYS_W-1:0] v);
    pad_word = 32'(v);
  endfunction : pad_word

  pmc_pkg::state_t state;
  pmc_pkg::state_t next_state;

  logic [SUBSYS_W-1:0]        act_tmpl;
  logic [SUBSYS_W-1:0]        alt_tmpl;
  logic [pmc_pkg::WAKE_W-1:0] wake_en;
  logic [1:0]                 reg_ctrl;
  logic [pmc_pkg::IRQ_W-1:0]  irq_status;
  logic [pmc_pkg::IRQ_W-1:0]  irq_enable;
  logic [15:0]                resume_cnt;
  logic [15:0]                next_resume_cnt;
  logic [pmc_pkg::WAKE_W-1:0] wake_prev;
  logic                       irq_prev;

  wire  [pmc_pkg::WAKE_W-1:0] wake_lvl;

  // Wake sources come from pins and slow-clock logic, so they are filtered
  input_sync #(
    .WIDTH (pmc_pkg::WAKE_W)
  ) u_wake_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .ce_in     (ce_in),
    .async_in  (wake_src_in),
    .level_out (wake_lvl)
  );

  // Bus decode
  wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire bus_wr  = bus_req & wb_we_in;

  wire sel_act_tmpl   = wb_adr_in == pmc_pkg::ADDR_ACT_TMPL;
  wire sel_alt_tmpl   = wb_adr_in == pmc_pkg::ADDR_ALT_TMPL;
  wire sel_mode_req   = wb_adr_in == pmc_pkg::ADDR_MODE_REQ;
  wire sel_mode_stat  = wb_adr_in == pmc_pkg::ADDR_MODE_STAT;
  wire sel_wake_en    = wb_adr_in == pmc_pkg::ADDR_WAKE_EN;
  wire sel_reg_ctrl   = wb_adr_in == pmc_pkg::ADDR_REG_CTRL;
  wire sel_irq_status = wb_adr_in == pmc_pkg::ADDR_IRQ_STATUS;
  wire sel_irq_clear  = wb_adr_in == pmc_pkg::ADDR_IRQ_CLEAR;
  wire sel_irq_enable = wb_adr_in == pmc_pkg::ADDR_IRQ_ENABLE;

  wire [31:0] wr_act_tmpl = merge_sel(pad_word(act_tmpl), wb_dat_in, wb_sel_in);
  wire [31:0] wr_alt_tmpl = merge_sel(pad_word(alt_tmpl), wb_dat_in, wb_sel_in);
  wire [31:0] wr_wake_en  = merge_sel(32'(wake_en), wb_dat_in, wb_sel_in);
  wire [31:0] wr_reg_ctrl = merge_sel(32'(reg_ctrl), wb_dat_in, wb_sel_in);
  wire [31:0] wr_irq_en   = merge_sel(32'(irq_enable), wb_dat_in, wb_sel_in);
  wire [31:0] wr_irq_clr  = merge_sel(32'h0000_0000, wb_dat_in, wb_sel_in);
  wire [31:0] wr_mode     = merge_sel(32'h0000_0000, wb_dat_in, wb_sel_in);

  // Mode request: only the low-power codes are honoured, and only from a run mode
  wire [1:0] req_code  = wr_mode[pmc_pkg::MODE_LSB +: 2];
  wire       run_state = (state == pmc_pkg::ST_ACTIVE) | (state == pmc_pkg::ST_ALT);
  wire       mode_wr   = bus_wr & sel_mode_req & run_state;               // [R18]
  wire       req_alt   = mode_wr & (req_code == pmc_pkg::MODE_ALT);       // [R18]
  wire       req_sleep = mode_wr & (req_code == pmc_pkg::MODE_SLEEP);     // [R18]
  wire       req_hib   = mode_wr & (req_code == pmc_pkg::MODE_HIB);       // [R18]

  // Wakeup detection on rising edges of the enabled sources
  wire [pmc_pkg::WAKE_W-1:0] wake_rise = wake_lvl & ~wake_prev & wake_en;  // [R16]
  wire irq_rise   = irq_pending_in & ~irq_prev;
  wire run_wake   = run_state & (irq_rise | (|wake_rise));                 // [R16]
  wire sleep_wake = (state == pmc_pkg::ST_SLEEP) & (|wake_rise);           // [R17]
  wire hib_wake   = (state == pmc_pkg::ST_HIB) & wake_rise[pmc_pkg::WAKE_PIN_UNIT]; // [R9]
  wire wake_evt   = run_wake | sleep_wake | hib_wake;
  wire resume_end = (state == pmc_pkg::ST_RESUME) & (resume_cnt == 16'h0000);

  // Mode sequencing
  always_comb begin
    next_state      = state;
    next_resume_cnt = resume_cnt;
    unique case (state)
      pmc_pkg::ST_ACTIVE,
      pmc_pkg::ST_ALT: begin
        if (run_wake) begin
          next_state = pmc_pkg::ST_ACTIVE;                                 // [R6]
        end else if (req_alt) begin
          next_state = pmc_pkg::ST_ALT;                                    // [R10]
        end else if (req_sleep) begin
          next_state = pmc_pkg::ST_SLEEP;                                  // [R8]
        end else if (req_hib) begin
          next_state = pmc_pkg::ST_HIB;                                    // [R9]
        end
      end
      pmc_pkg::ST_SLEEP: begin
        if (sleep_wake) begin
          next_state      = pmc_pkg::ST_RESUME;
          next_resume_cnt = SLEEP_RESUME_CYC - 16'h0001;                   // [R14]
        end
      end
      pmc_pkg::ST_HIB: begin
        if (hib_wake) begin
          next_state      = pmc_pkg::ST_RESUME;
          next_resume_cnt = HIB_RESUME_CYC - 16'h0001;                     // [R15]
        end
      end
      pmc_pkg::ST_RESUME: begin
        if (resume_cnt == 16'h0000) begin
          next_state = pmc_pkg::ST_ACTIVE;                                 // [R6]
        end else begin
          next_resume_cnt = resume_cnt - 16'h0001;
        end
      end
      default: begin
        next_state = pmc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Template update; a wakeup re-sets the processor bit over a firmware clear
  wire [SUBSYS_W-1:0] tmpl_wr_val = (bus_wr & sel_act_tmpl) ?
                                    wr_act_tmpl[SUBSYS_W-1:0] : act_tmpl;   // [R4]
  wire [SUBSYS_W-1:0] cpu_force   = wake_evt ? SUBSYS_W'(1 << pmc_pkg::CPU_BIT) : '0;
  wire [SUBSYS_W-1:0] next_act_tmpl = tmpl_wr_val | cpu_force;             // [R5]
  wire [SUBSYS_W-1:0] next_alt_tmpl = (bus_wr & sel_alt_tmpl) ?
                                      wr_alt_tmpl[SUBSYS_W-1:0] : alt_tmpl; // [R4]

  // Resource enables per mode
  wire [SUBSYS_W-1:0] next_en =
      (next_state == pmc_pkg::ST_ACTIVE) ? next_act_tmpl :                 // [R2]
      (next_state == pmc_pkg::ST_ALT)    ? next_alt_tmpl :                 // [R10]
      (next_state == pmc_pkg::ST_SLEEP)  ? SLEEP_KEEP : '0;                // [R8]

  wire [1:0] mode_code =
      (next_state == pmc_pkg::ST_ALT)   ? pmc_pkg::MODE_ALT :
      (next_state == pmc_pkg::ST_SLEEP) ? pmc_pkg::MODE_SLEEP :
      (next_state == pmc_pkg::ST_HIB)   ? pmc_pkg::MODE_HIB : pmc_pkg::MODE_ACTIVE; // [R1]

  wire [1:0] next_reg_ctrl = (bus_wr & sel_reg_ctrl) ? wr_reg_ctrl[1:0] : reg_ctrl;
  wire next_hib   = next_state == pmc_pkg::ST_HIB;
  wire next_sleep = next_state == pmc_pkg::ST_SLEEP;

  // Sticky events, a set in the same cycle as its clear wins
  wire [pmc_pkg::IRQ_W-1:0] irq_evt = {req_sleep | req_hib, resume_end, wake_evt};
  wire [pmc_pkg::IRQ_W-1:0] irq_clr = (bus_wr & sel_irq_clear) ?
                                      wr_irq_clr[pmc_pkg::IRQ_W-1:0] : '0;
  wire [pmc_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_evt;
  wire [pmc_pkg::IRQ_W-1:0] next_irq_enable = (bus_wr & sel_irq_enable) ?
                                              wr_irq_en[pmc_pkg::IRQ_W-1:0] : irq_enable;

  // Read data; unmapped and write-only offsets read zero
  wire [31:0] stat_word = 32'({state == pmc_pkg::ST_RESUME, mode_out});
  wire [31:0] rd_data =
      sel_act_tmpl   ? pad_word(act_tmpl) :
      sel_alt_tmpl   ? pad_word(alt_tmpl) :
      sel_mode_stat  ? stat_word :
      sel_wake_en    ? 32'(wake_en) :
      sel_reg_ctrl   ? 32'(reg_ctrl) :
      sel_irq_status ? 32'(irq_status) :
      sel_irq_enable ? 32'(irq_enable) : 32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state      <= pmc_pkg::ST_ACTIVE;                                    // [R7]
      resume_cnt <= 16'h0000;
      wake_prev  <= '0;
      irq_prev   <= 1'b0;
    end else if (ce_in) begin
      state      <= next_state;
      resume_cnt <= next_resume_cnt;
      wake_prev  <= wake_lvl;
      irq_prev   <= irq_pending_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      act_tmpl   <= pmc_pkg::RST_TMPL[SUBSYS_W-1:0];
      alt_tmpl   <= pmc_pkg::RST_TMPL[SUBSYS_W-1:0];
      wake_en    <= pmc_pkg::RST_WAKE_EN;
      reg_ctrl   <= pmc_pkg::RST_REG_CTRL;                                 // [R11]
      irq_status <= '0;
      irq_enable <= pmc_pkg::RST_IRQ_EN;
    end else if (ce_in) begin
      act_tmpl   <= next_act_tmpl;
      alt_tmpl   <= next_alt_tmpl;
      wake_en    <= (bus_wr & sel_wake_en) ? wr_wake_en[pmc_pkg::WAKE_W-1:0] : wake_en;
      reg_ctrl   <= next_reg_ctrl;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else if (ce_in) begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      subsys_clk_en_out  <= pmc_pkg::RST_TMPL[SUBSYS_W-1:0];
      subsys_bias_en_out <= pmc_pkg::RST_TMPL[SUBSYS_W-1:0];
      dig_reg_en_out     <= 1'b1;                                          // [R11]
      ana_reg_en_out     <= 1'b1;                                          // [R11]
      reg_buzz_out       <= 1'b0;
      hib_reg_en_out     <= 1'b0;
      clk_stop_out       <= 1'b0;
      low_speed_clk_out  <= 1'b0;
      mode_out           <= pmc_pkg::MODE_ACTIVE;                          // [R7]
      resuming_out       <= 1'b0;
      irq_out            <= 1'b0;
    end else if (ce_in) begin
      subsys_clk_en_out  <= next_en;                                       // [R3]
      subsys_bias_en_out <= next_en;                                       // [R3]
      dig_reg_en_out     <= next_reg_ctrl[pmc_pkg::REG_DIG_BIT] & ~next_hib; // [R13]
      ana_reg_en_out     <= next_reg_ctrl[pmc_pkg::REG_ANA_BIT] & ~next_hib; // [R13]
      reg_buzz_out       <= next_sleep;                                    // [R12]
      hib_reg_en_out     <= next_hib;                                      // [R13]
      clk_stop_out       <= next_hib;                                      // [R9]
      low_speed_clk_out  <= next_sleep;
      mode_out           <= mode_code;                                     // [R6]
      resuming_out       <= next_state == pmc_pkg::ST_RESUME;
      irq_out            <= |(next_irq_status & next_irq_enable);
    end
  end

endmodule : power_mode_controller

// ===== power_mode_controller_asserts.sv
// Port-level property checker for the power mode controller
`timescale 1ns/10ps
module power_mode_controller_asserts #(
  parameter int unsigned         SUBSYS_W         = pmc_pkg::SUBSYS_W,
  parameter logic [15:0]         SLEEP_RESUME_CYC = pmc_pkg::SLEEP_RESUME_CYC,
  parameter logic [15:0]         HIB_RESUME_CYC   = pmc_pkg::HIB_RESUME_CYC,
  parameter logic [SUBSYS_W-1:0] SLEEP_KEEP       = '0
) (
  input wire logic                clk_in,
  input wire logic                rst_b_in,
  input wire logic                ce_in,
  input wire logic                wb_cyc_in,
  input wire logic                wb_stb_in,
  input wire logic                wb_ack_out,
  input wire logic [SUBSYS_W-1:0] subsys_clk_en_out,
  input wire logic [SUBSYS_W-1:0] subsys_bias_en_out,
  input wire logic                dig_reg_en_out,
  input wire logic                ana_reg_en_out,
  input wire logic                reg_buzz_out,
  input wire logic                hib_reg_en_out,
  input wire logic                clk_stop_out,
  input wire logic                low_speed_clk_out,
  input wire logic [1:0]          mode_out,
  input wire logic                resuming_out,
  input wire logic                irq_out
);
  localparam logic [16:0] RES_MAX = 17'((SLEEP_RESUME_CYC > HIB_RESUME_CYC) ?
                                        SLEEP_RESUME_CYC : HIB_RESUME_CYC);
  logic [16:0] res_cnt;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Length of the current resume wait
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !resuming_out) res_cnt <= '0;
    else if (ce_in) res_cnt <= res_cnt + 17'h00001;
  end

  bias_match_a: assert property (subsys_bias_en_out == subsys_clk_en_out)
    else $error("bias enable differs from clock enable");
  sleep_gate_a: assert property (mode_out == pmc_pkg::MODE_SLEEP |->
    subsys_clk_en_out == SLEEP_KEEP)
    else $error("subsystem left running in sleep");
  sleep_buzz_a: assert property ((mode_out == pmc_pkg::MODE_SLEEP) ==
    (reg_buzz_out && low_speed_clk_out))
    else $error("buzz or low speed clock out of step with sleep");
  hib_supply_a: assert property (mode_out == pmc_pkg::MODE_HIB |-> clk_stop_out &&
    !dig_reg_en_out && !ana_reg_en_out && subsys_clk_en_out == '0)
    else $error("supply or clocks wrong in hibernate");
  hib_match_a: assert property ((mode_out == pmc_pkg::MODE_HIB) == hib_reg_en_out)
    else $error("hibernate regulator out of step with mode");
  resume_len_a: assert property ($fell(resuming_out) |->
    res_cnt >= 17'h00001 && res_cnt <= RES_MAX)
    else $error("resume wait too long");
  resume_quiet_a: assert property (resuming_out |-> mode_out == pmc_pkg::MODE_ACTIVE &&
    subsys_clk_en_out == '0 && !reg_buzz_out)
    else $error("resume state outputs wrong");
  wake_cpu_a: assert property ($fell(resuming_out) |->
    ##[0:1] subsys_clk_en_out[pmc_pkg::CPU_BIT])
    else $error("processor not enabled after wakeup");
  boot_active_a: assert property ($rose(rst_b_in) |->
    mode_out == pmc_pkg::MODE_ACTIVE && dig_reg_en_out && ana_reg_en_out)
    else $error("not active with regulators on after reset");
  ack_pulse_a: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("bus request not answered next cycle");

  sleep_c: cover property (mode_out == pmc_pkg::MODE_SLEEP);
  hib_c:   cover property (mode_out == pmc_pkg::MODE_HIB);
  res_c:   cover property ($fell(resuming_out));
  irq_c:   cover property (irq_out);
endmodule : power_mode_controller_asserts

bind power_mode_controller power_mode_controller_asserts #(.SUBSYS_W(SUBSYS_W),
  .SLEEP_RESUME_CYC(SLEEP_RESUME_CYC), .HIB_RESUME_CYC(HIB_RESUME_CYC), .SLEEP_KEEP(SLEEP_KEEP))
  i_asserts (.clk_in, .rst_b_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .subsys_clk_en_out,
  .subsys_bias_en_out, .dig_reg_en_out, .ana_reg_en_out, .reg_buzz_out, .hib_reg_en_out,
  .clk_stop_out, .low_speed_clk_out, .mode_out, .resuming_out, .irq_out);

// ===== power_mode_controller_test.sv
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
module power_mode_controller_test;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} note_t;
  logic clk_in = 0, rst_b_in = 0, ce_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic [7:0]  wb_adr_in = '0;
  logic [3:0]  wb_sel_in = '0;
  logic [31:0] wb_dat_in = '0, wb_dat_out;
  logic [5:0]  wake_src_in = '0;
  logic        irq_pending_in = 0, wb_ack_out, dig_reg_en_out, ana_reg_en_out, reg_buzz_out;
  logic        hib_reg_en_out, clk_stop_out, low_speed_clk_out, resuming_out, irq_out;
  logic [7:0]  subsys_clk_en_out, subsys_bias_en_out;
  logic [1:0]  mode_out;
  note_t       notes[$];
  int          error_cnt = 0, cmp_count = 0, seed = 54273, s;
  logic [31:0] t;

  power_mode_controller #(.SLEEP_RESUME_CYC(16'h0004), .HIB_RESUME_CYC(16'h0004)) i_dut (
    .clk_in, .rst_b_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .wake_src_in, .irq_pending_in, .subsys_clk_en_out,
    .subsys_bias_en_out, .dig_reg_en_out, .ana_reg_en_out, .reg_buzz_out, .hib_reg_en_out,
    .clk_stop_out, .low_speed_clk_out, .mode_out, .resuming_out, .irq_out);

  always #4 clk_in = ~clk_in;

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task check_out(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: output %h expected %h", $time, got, exp);
    end
  endtask : check_out

  task check_rd(input logic [31:0] got, input note_t n);
    cmp_count++;
    if ((got & n.m) !== n.v) begin
      error_cnt++;
      $display("Error at %0t: read %h expected %h", $time, got, n.v);
    end
  endtask : check_rd

  // Read results are paired with the oldest note at each read ack
  always @(posedge clk_in) begin
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
      if (notes.size() == 0) check_out(32'h1, 32'h0);
      else check_rd(wb_dat_out, notes.pop_front());
    end
  end

  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= 4'hF;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (wb_ack_out !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: no ack", $time);
      finish_test;
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask : wb_xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back({v, m});
    wb_xfer(1'b0, a, 32'h0);
  endtask : rd

  task settle(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : settle

  // Waits: 0 for a settled mode, 1 for processor enable, 2 for interrupt
  task wait_for(input int what, input logic [1:0] m);
    int n;
    n = 0;
    while (n < 300 && !((what == 0 && mode_out === m && resuming_out === 1'b0) ||
           (what == 1 && subsys_clk_en_out[0] === 1'b1) || (what == 2 && irq_out === 1'b1))) begin
      settle(1);
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      $display("Error at %0t: wait expired", $time);
      finish_test;
    end
    settle(1);
  endtask : wait_for

  task sleep_wake(input logic [5:0] src, input logic [7:0] exp);
    wr(pmc_pkg::ADDR_MODE_REQ, 32'(pmc_pkg::MODE_SLEEP));
    wait_for(0, pmc_pkg::MODE_SLEEP);
    check_out({reg_buzz_out, low_speed_clk_out, subsys_clk_en_out}, 32'h300);
    @(posedge clk_in) wake_src_in <= src;
    wait_for(0, pmc_pkg::MODE_ACTIVE);
    check_out(32'(subsys_clk_en_out), 32'(exp));
    @(posedge clk_in) wake_src_in <= '0;
  endtask : sleep_wake

  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    check_out({mode_out, dig_reg_en_out, ana_reg_en_out,
               subsys_clk_en_out}, 32'h3FF);
    rd(pmc_pkg::ADDR_WAKE_EN, 32'h3F, '1);
    rd(pmc_pkg::ADDR_REG_CTRL, 32'h3, '1);
    rd(pmc_pkg::ADDR_IRQ_ENABLE, 32'h0, '1);
    wr(8'h24, '1);
    rd(8'h24, 32'h0, '1);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      t = $random(seed);
      wr(pmc_pkg::ADDR_ACT_TMPL, t);
      settle(1);
      check_out(32'(subsys_clk_en_out), {24'h0, t[7:0]});
      rd(pmc_pkg::ADDR_ACT_TMPL, {24'h0, t[7:0]}, '1);
    end
    $display("test templates done");
    wr(pmc_pkg::ADDR_ACT_TMPL, 32'hF0);
    settle(1);
    check_out(32'(subsys_clk_en_out), 32'hF0);
    @(posedge clk_in);
    irq_pending_in <= 1'b1;
    wait_for(1, 2'h0);
    rd(pmc_pkg::ADDR_ACT_TMPL, 32'hF1, '1);
    irq_pending_in <= 1'b0;
    wr(pmc_pkg::ADDR_ACT_TMPL, 32'hF0);
    wr(pmc_pkg::ADDR_ALT_TMPL, 32'h3C);
    wr(pmc_pkg::ADDR_MODE_REQ, 32'(pmc_pkg::MODE_ALT));
    wait_for(0, pmc_pkg::MODE_ALT);
    check_out(32'(subsys_clk_en_out), 32'h3C);
    rd(pmc_pkg::ADDR_MODE_STAT, 32'h1, 32'h7);
    irq_pending_in <= 1'b1;
    wait_for(0, pmc_pkg::MODE_ACTIVE);
    check_out(32'(subsys_clk_en_out), 32'hF1);
    @(posedge clk_in) irq_pending_in <= 1'b0;
    $display("test wakeup done");
    wr(pmc_pkg::ADDR_ACT_TMPL, 32'h5A);
    for (s = 0; s < 6; s++) sleep_wake(6'(1 << s), 8'h5B);
    wr(pmc_pkg::ADDR_WAKE_EN, 32'h3E);
    wr(pmc_pkg::ADDR_MODE_REQ, 32'(pmc_pkg::MODE_SLEEP));
    wake_src_in <= 6'h01;
    settle(12);
    check_out(32'(mode_out), 32'(pmc_pkg::MODE_SLEEP));
    @(posedge clk_in) wake_src_in <= 6'h00;
    sleep_wake(6'h20, 8'h5B);
    wr(pmc_pkg::ADDR_WAKE_EN, 32'h3F);
    $display("test sleep done");
    wr(pmc_pkg::ADDR_MODE_REQ, 32'(pmc_pkg::MODE_HIB));
    wait_for(0, pmc_pkg::MODE_HIB);
    check_out({hib_reg_en_out, clk_stop_out, dig_reg_en_out, ana_reg_en_out}, 32'hC);
    @(posedge clk_in) wake_src_in <= 6'h01;
    settle(12);
    check_out(32'(mode_out), 32'(pmc_pkg::MODE_HIB));
    @(posedge clk_in) wake_src_in <= 6'h03;
    wait_for(0, pmc_pkg::MODE_ACTIVE);
    check_out({hib_reg_en_out, dig_reg_en_out, ana_reg_en_out}, 32'h3);
    @(posedge clk_in) wake_src_in <= 6'h00;
    wr(pmc_pkg::ADDR_REG_CTRL, 32'h0);
    settle(1);
    check_out({dig_reg_en_out, ana_reg_en_out}, 32'h0);
    wr(pmc_pkg::ADDR_REG_CTRL, 32'h3);
    $display("test hibernate done");
    rd(pmc_pkg::ADDR_IRQ_STATUS, 32'h7, 32'h7);
    wr(pmc_pkg::ADDR_IRQ_CLEAR, 32'h7);
    rd(pmc_pkg::ADDR_IRQ_STATUS, 32'h0, 32'h7);
    wr(pmc_pkg::ADDR_IRQ_ENABLE, 32'h1);
    irq_pending_in <= 1'b1;
    wait_for(2, 2'h0);
    wr(pmc_pkg::ADDR_IRQ_ENABLE, 32'h0);
    settle(1);
    check_out(32'(irq_out), 32'h0);
    rd(pmc_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1);
    wr(pmc_pkg::ADDR_IRQ_ENABLE, 32'h1);
    settle(1);
    check_out(32'(irq_out), 32'h1);
    wr(pmc_pkg::ADDR_IRQ_CLEAR, 32'h1);
    settle(1);
    check_out(32'(irq_out), 32'h0);
    @(posedge clk_in) irq_pending_in <= 1'b0;
    $display("test interrupt done");
    settle(4);
    check_out(32'(notes.size()), 32'h0);
    finish_test;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    error_cnt++;
    $display("Error at %0t: run limit reached", $time);
    finish_test;
  end
endmodule : power_mode_controller_test
